// >>> hdl/event_code_select.sv
`timescale 1ns/10ps
`default_nettype none
module event_code_select
  import status_irq_pkg::*;
(
  // enabled sources
  input  wire logic [NUM_SRC-1:0] i_pending,
  // chosen code
  output logic      [3:0]         o_code,
  output logic                    o_any
);

  function automatic logic [3:0] src_code(input int idx);
    if (idx == SRC_PARITY) begin
      return CODE_PARITY;
    end else if (idx == SRC_RANGE) begin
      return CODE_RANGE;
    end else if (idx == SRC_SUPPLY) begin
      return CODE_SUPPLY;
    end
    return 4'(idx);
  endfunction : src_code

  // highest source wins, so supply loss takes precedence
  always_comb begin
    o_code = CODE_NONE;
    for (int i = 1; i < NUM_SRC; i++) begin
      if (i_pending[i]) begin
        o_code = src_code(i);
      end
    end
    o_any = |i_pending[NUM_SRC-1:1];
  end

endmodule : event_code_select
`default_nettype wire

// >>> hdl/fault_addr_latch.sv
`timescale 1ns/10ps
`default_nettype none
module fault_addr_latch
  import status_irq_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  // fault capture
  input  wire logic              i_fault,
  input  wire logic [WORD_W-1:0] i_addr,
  // release on read
  input  wire logic              i_release,
  // held address
  output logic      [WORD_W-1:0] o_addr,
  output logic                   o_blocked
);

  logic blocked_r;

  // address is frozen from the first fault until released
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_addr <= FAULT_ADDR_RST;
    end else if (i_fault && !blocked_r) begin
      o_addr <= i_addr;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      blocked_r <= 1'b0;
    end else if (i_fault) begin
      blocked_r <= 1'b1;
    end else if (i_release) begin
      blocked_r <= 1'b0;
    end
  end

  assign o_blocked = blocked_r;

endmodule : fault_addr_latch
`default_nettype wire

// >>> hdl/internal_status_interrupt_unit.sv
// Overview of operation
// - enabled events request level fourteen only
// - eleven-bit enable mask loaded by register write
// - bits one to seven map to codes
// - parity fault: bit eight, code octal ten
// - out of range: bit nine, code eleven
// - supply loss bit ten, code twelve, wins
// - code read fills bits 0-3, zero above
// - reading the code clears it
// - program counter advanced before event taken
// - fetch-time range, page, protect: no advance
// - prior level read gives fetch opcode
// - prior level updated only from lower levels
// - call number sign-extended into level-14 T
// - error flag re-raises until software clears
// - error flag set by five causes
// - protect on bad reference or ring
// - missing page raises its event
// - unimplemented opcode raises bad-opcode event
// - privileged op without right raises fault
// - no connect response raises I/O error
// - fault address holds low sixteen bits
// - level request bit fourteen set internally
// - give-up clears running level request bit
`timescale 1ns/10ps
`default_nettype none
module internal_status_interrupt_unit
  import status_irq_pkg::*;
#(
  parameter logic [15:0] FETCH_OP_BASE = 16'h0000
)(
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_sys_rst,
  // register read and write instructions
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  input  wire logic [2:0]                    i_reg_sel,
  input  wire logic [status_irq_pkg::WORD_W-1:0] i_wr_data,
  output logic      [status_irq_pkg::WORD_W-1:0] o_rd_data,
  output logic                               o_rd_valid,
  // running level and level switching
  input  wire logic [3:0]                    i_cur_level,
  input  wire logic                          i_level_switch,
  input  wire logic [3:0]                    i_new_level,
  input  wire logic                          i_give_up,
  input  wire logic [15:0]                   i_ext_level_req,
  output logic      [15:0]                   o_level_req,
  // fault sources from execution, paging and memory
  input  wire logic                          i_svc_call,
  input  wire logic [7:0]                    i_svc_num,
  input  wire logic                          i_ref_type_bad,
  input  wire logic                          i_ring_violation,
  input  wire logic                          i_page_missing,
  input  wire logic                          i_bad_opcode,
  input  wire logic                          i_priv_op_fault,
  input  wire logic                          i_io_no_connect,
  input  wire logic                          i_mem_parity_fault,
  input  wire logic                          i_addr_out_of_range,
  input  wire logic [status_irq_pkg::WORD_W-1:0] i_fault_addr,
  input  wire logic                          i_fetch_cycle,
  input  wire logic                          i_supply_loss,
  // error flag causes and software control
  input  wire logic                          i_fdiv_zero,
  input  wire logic                          i_exec_of_exec,
  input  wire logic                          i_denorm_ovf,
  input  wire logic                          i_reg_divide_ovf,
  input  wire logic                          i_err_flag_set,
  input  wire logic                          i_err_flag_clr,
  input  wire logic [3:0]                    i_err_flag_level,
  output logic      [15:0]                   o_err_flags,
  // program counter and paging status
  output logic                               o_pc_advance,
  output logic                               o_pc_hold,
  output logic                               o_pgs_fetch_flag,
  // level-14 T register load
  output logic                               o_t14_load,
  output logic      [status_irq_pkg::WORD_W-1:0] o_t14_value
);

  logic [NUM_SRC-1:0] event_en_r;
  logic [3:0]         event_code_r;
  logic [3:0]         event_code_nxt;
  level_t             prior_level_r;
  logic [15:0]        err_flags_r;
  logic [NUM_SRC-1:0] raw_events;
  logic [NUM_SRC-1:0] pending;
  logic [3:0]         sel_code;
  logic               sel_any;
  logic               supply_s1_r;
  logic               supply_s2_r;
  logic               supply_s3_r;
  logic               supply_lvl_r;
  logic               supply_rise;
  logic               fault_mem;
  logic               code_read;
  logic               addr_read;
  logic               fetch_abort;
  logic               err_running;
  logic               on_top_level;
  logic               flag_cause;
  logic               mask_wr;
  logic               req_wr;
  logic               enter_internal;
  logic               paging_fetch;
  logic               svc_taken;
  logic [WORD_W-1:0]  fault_addr;
  logic [WORD_W-1:0]  rd_word;

  function automatic logic [WORD_W-1:0] sign_ext8(input logic [7:0] v);
    return {{(WORD_W-SVC_W){v[SVC_W-1]}}, v};
  endfunction : sign_ext8

  function automatic logic sel_hit(input logic [2:0] sel,
                                   input logic [2:0] which);
    return sel == which;
  endfunction : sel_hit

  // supply loss pin: three stages, accept when stage two and three agree
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      supply_s1_r <= 1'b0;
      supply_s2_r <= 1'b0;
      supply_s3_r <= 1'b0;
    end else begin
      supply_s1_r <= i_supply_loss;
      supply_s2_r <= supply_s1_r;
      supply_s3_r <= supply_s2_r;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      supply_lvl_r <= 1'b0;
    end else if (supply_s2_r == supply_s3_r) begin
      supply_lvl_r <= supply_s3_r;
    end
  end

  // one-cycle event on the agreed rising level
  assign supply_rise = (supply_s2_r == supply_s3_r) && supply_s3_r
                       && !supply_lvl_r;

  // any of the five causes sets the running level's flag
  assign flag_cause = i_fdiv_zero || i_exec_of_exec || i_denorm_ovf
                      || i_reg_divide_ovf || i_err_flag_set;

  // per-level error flag of the status word, set beats clear
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      err_flags_r <= ERR_FLAGS_RST;
    end else begin
      for (int l = 0; l < NUM_LEVELS; l++) begin
        if (flag_cause && i_cur_level == 4'(l)) begin
          err_flags_r[l] <= 1'b1;
        end else if (i_err_flag_clr && i_err_flag_level == 4'(l)) begin
          err_flags_r[l] <= 1'b0;
        end
      end
    end
  end

  // levels fourteen and fifteen never raise the flag event on themselves
  assign on_top_level = i_cur_level == LEVEL_INTERNAL
                        || i_cur_level == LEVEL_FAST;

  assign err_running = err_flags_r[i_cur_level] && !on_top_level;

  // raw source vector, bit zero unassigned
  always_comb begin
    raw_events               = '0;
    raw_events[SRC_SVC]      = i_svc_call;
    raw_events[SRC_PROTECT]  = i_ref_type_bad || i_ring_violation;
    raw_events[SRC_PAGE]     = i_page_missing;
    raw_events[SRC_BAD_OP]   = i_bad_opcode;
    raw_events[SRC_ERR_FLAG] = err_running;
    raw_events[SRC_PRIV]     = i_priv_op_fault;
    raw_events[SRC_IO]       = i_io_no_connect;
    raw_events[SRC_PARITY]   = i_mem_parity_fault;
    raw_events[SRC_RANGE]    = i_addr_out_of_range;
    raw_events[SRC_SUPPLY]   = supply_rise;
  end

  // masked sources are dropped before anything latches
  assign pending = raw_events & event_en_r;

  // priority pick of the code to latch
  event_code_select u_select (
    .i_pending (pending),
    .o_code    (sel_code),
    .o_any     (sel_any)
  );

  assign fault_mem = pending[SRC_PARITY] || pending[SRC_RANGE];
  assign code_read = i_reg_rd && sel_hit(i_reg_sel, SEL_EVENT_CODE);
  assign addr_read = i_reg_rd && sel_hit(i_reg_sel, SEL_FAULT_ADDR);
  assign mask_wr   = i_reg_wr && sel_hit(i_reg_sel, SEL_EVENT_EN);
  assign req_wr    = i_reg_wr && sel_hit(i_reg_sel, SEL_LEVEL_REQ);

  // fault address held from the first memory fault until read
  fault_addr_latch u_fault_addr (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_fault   (fault_mem),
    .i_addr    (i_fault_addr),
    .i_release (addr_read),
    .o_addr    (fault_addr),
    .o_blocked ()
  );

  // enable mask, loaded only by the register write instruction
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      event_en_r <= EVENT_EN_RST;
    end else if (mask_wr) begin
      event_en_r <= i_wr_data[NUM_SRC-1:0];
    end
  end

  // new event beats the clearing read in the same cycle
  always_comb begin
    event_code_nxt = event_code_r;
    if (code_read) begin
      event_code_nxt = CODE_NONE;
    end
    if (sel_any) begin
      event_code_nxt = sel_code;
    end
  end

  // code register, held until read or overwritten
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      event_code_r <= EVENT_CODE_RST;
    end else begin
      event_code_r <= event_code_nxt;
    end
  end

  // entry to fourteen from a lower level only; fifteen leaves it alone
  assign enter_internal = i_level_switch && i_new_level == LEVEL_INTERNAL
                          && i_cur_level < LEVEL_INTERNAL;

  // prior level recorded only on entry to fourteen from below
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prior_level_r <= PRIOR_LEVEL_RST;
    end else if (enter_internal) begin
      prior_level_r <= i_cur_level;
    end
  end

  // level request bits: set from events and pins, cleared by give-up
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_level_req <= LEVEL_REQ_RST;
    end else begin
      for (int l = 0; l < NUM_LEVELS; l++) begin
        if (l == int'(LEVEL_INTERNAL) && sel_any) begin
          o_level_req[l] <= 1'b1;
        end else if (l != int'(LEVEL_INTERNAL) && i_ext_level_req[l]) begin
          o_level_req[l] <= 1'b1;
        end else if (i_give_up && i_cur_level == 4'(l)) begin
          o_level_req[l] <= 1'b0;
        end else if (req_wr) begin
          o_level_req[l] <= i_wr_data[l];
        end
      end
    end
  end

  // read word assembly
  always_comb begin
    rd_word = '0;
    unique case (i_reg_sel)
      SEL_EVENT_CODE: begin
        rd_word[CODE_LSB +: CODE_W] = event_code_r;
      end
      SEL_PRIOR_LEVEL: begin
        rd_word = FETCH_OP_BASE;
        rd_word[PRIOR_LSB +: PRIOR_W] = prior_level_r;
      end
      SEL_LEVEL_REQ: begin
        rd_word = o_level_req;
      end
      SEL_FAULT_ADDR: begin
        rd_word = fault_addr;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  // registered answer, data held until the next read
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data  <= '0;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_reg_rd;
      if (i_reg_rd) begin
        o_rd_data <= rd_word;
      end
    end
  end

  // program counter control for the faulting level
  assign fetch_abort = i_fetch_cycle && (pending[SRC_RANGE]
                       || pending[SRC_PAGE] || pending[SRC_PROTECT]);
  assign paging_fetch = i_fetch_cycle && (pending[SRC_PAGE]
                        || pending[SRC_PROTECT]);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pc_advance     <= 1'b0;
      o_pc_hold        <= 1'b0;
      o_pgs_fetch_flag <= 1'b0;
    end else begin
      o_pc_advance     <= sel_any && !fetch_abort;
      o_pc_hold        <= fetch_abort;
      o_pgs_fetch_flag <= paging_fetch;
    end
  end

  assign svc_taken = pending[SRC_SVC];

  // supervisor call number to level-14 T register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_t14_load  <= 1'b0;
      o_t14_value <= '0;
    end else begin
      o_t14_load <= svc_taken;
      if (svc_taken) begin
        o_t14_value <= sign_ext8(i_svc_num);
      end
    end
  end

  assign o_err_flags = err_flags_r;

endmodule : internal_status_interrupt_unit
`default_nettype wire

// >>> hdl/status_irq_pkg.sv
package status_irq_pkg;

  // levels
  localparam logic [3:0]  LEVEL_INTERNAL  = 4'he;
  localparam logic [3:0]  LEVEL_FAST      = 4'hf;
  localparam int          NUM_LEVELS      = 16;
  localparam int          WORD_W          = 16;

  // enable mask layout, one bit per source
  localparam int          NUM_SRC         = 11;
  localparam int          SRC_SVC         = 1;
  localparam int          SRC_PROTECT     = 2;
  localparam int          SRC_PAGE        = 3;
  localparam int          SRC_BAD_OP      = 4;
  localparam int          SRC_ERR_FLAG    = 5;
  localparam int          SRC_PRIV        = 6;
  localparam int          SRC_IO          = 7;
  localparam int          SRC_PARITY      = 8;
  localparam int          SRC_RANGE       = 9;
  localparam int          SRC_SUPPLY      = 10;

  // latched codes (parity 10, range 11, supply 12 octal)
  localparam logic [3:0]  CODE_NONE       = 4'h0;
  localparam logic [3:0]  CODE_PARITY     = 4'h8;
  localparam logic [3:0]  CODE_RANGE      = 4'h9;
  localparam logic [3:0]  CODE_SUPPLY     = 4'ha;

  // read word field positions
  localparam int          CODE_LSB        = 0;
  localparam int          CODE_W          = 4;
  localparam int          PRIOR_LSB       = 3;
  localparam int          PRIOR_W         = 4;
  localparam int          SVC_W           = 8;

  // register selects for read and write instructions
  localparam logic [2:0]  SEL_EVENT_EN    = 3'h0;
  localparam logic [2:0]  SEL_EVENT_CODE  = 3'h1;
  localparam logic [2:0]  SEL_PRIOR_LEVEL = 3'h2;
  localparam logic [2:0]  SEL_LEVEL_REQ   = 3'h3;
  localparam logic [2:0]  SEL_FAULT_ADDR  = 3'h4;

  // reset values
  localparam logic [10:0] EVENT_EN_RST    = 11'h000;
  localparam logic [3:0]  EVENT_CODE_RST  = 4'h0;
  localparam logic [3:0]  PRIOR_LEVEL_RST = 4'h0;
  localparam logic [15:0] LEVEL_REQ_RST   = 16'h0000;
  localparam logic [15:0] FAULT_ADDR_RST  = 16'h0000;
  localparam logic [15:0] ERR_FLAGS_RST   = 16'h0000;

  typedef logic [3:0] level_t;

endpackage : status_irq_pkg

// >>> test/level_seq_model.sv
`timescale 1ns/10ps
`default_nettype none
module level_seq_model
  import status_irq_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // requests and wishes
  input  wire logic [15:0] i_level_req,
  input  wire logic [3:0]  i_base,
  input  wire logic        i_want_top,
  // level sequencer
  output logic      [3:0]  o_cur_level,
  output logic             o_level_switch,
  output logic      [3:0]  o_new_level
);
  level_t target;

  // highest wanted level wins; 14 is entered from below or from 15
  always_comb begin
    target = i_want_top ? LEVEL_FAST :
             (i_level_req[14] ? LEVEL_INTERNAL : i_base);
  end

  // one switch pulse, then the new level runs
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cur_level    <= 4'h0;
      o_level_switch <= 1'b0;
      o_new_level    <= 4'h0;
    end else if (!o_level_switch && o_cur_level != target) begin
      o_level_switch <= 1'b1;
      o_new_level    <= target;
    end else begin
      if (o_level_switch) begin
        o_cur_level <= o_new_level;
      end
      o_level_switch <= 1'b0;
    end
  end
endmodule : level_seq_model
`default_nettype wire

// >>> test/status_irq_sva.sv
`timescale 1ns/10ps
`default_nettype none
module status_irq_sva
  import status_irq_pkg::*;
#(
  parameter logic [15:0] FETCH_OP_BASE = 16'h0000
)(
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [2:0]  i_reg_sel,
  input wire logic [3:0]  i_cur_level,
  input wire logic        i_give_up,
  input wire logic [15:0] i_ext_level_req,
  input wire logic        i_svc_call,
  input wire logic [7:0]  i_svc_num,
  input wire logic        i_ref_type_bad,
  input wire logic        i_ring_violation,
  input wire logic        i_page_missing,
  input wire logic        i_fetch_cycle,
  input wire logic [15:0] o_rd_data,
  input wire logic        o_rd_valid,
  input wire logic [15:0] o_level_req,
  input wire logic        o_pc_advance,
  input wire logic        o_pc_hold,
  input wire logic        o_pgs_fetch_flag,
  input wire logic        o_t14_load,
  input wire logic [15:0] o_t14_value
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_rd_answer: assert property (o_rd_valid |-> $past(i_reg_rd))
    else $error("read answer without read");
  a_code_fmt: assert property (i_reg_rd && i_reg_sel == SEL_EVENT_CODE
    |=> o_rd_valid && o_rd_data[15:4] == 12'h000)
    else $error("code read upper bits not zero");
  a_prior_fmt: assert property (i_reg_rd && i_reg_sel == SEL_PRIOR_LEVEL
    |=> o_rd_valid && (o_rd_data & 16'hff87) == (FETCH_OP_BASE & 16'hff87))
    else $error("prior level read opcode bits wrong");
  a_t14_cause: assert property (o_t14_load |-> $past(i_svc_call))
    else $error("t register load without call");
  a_svc_sign: assert property (o_t14_load |-> o_t14_value ==
    {{8{$past(i_svc_num[7])}}, $past(i_svc_num)})
    else $error("call number not sign extended");
  a_fetch_hold: assert property (o_pc_hold
    |-> $past(i_fetch_cycle) && !o_pc_advance)
    else $error("hold without fetch fault");
  a_pgs_flag: assert property (o_pgs_fetch_flag |-> o_pc_hold &&
    $past(i_page_missing || i_ref_type_bad || i_ring_violation))
    else $error("paging fetch flag without paging fault");
  a_adv_excl: assert property (o_pc_advance |-> !o_pgs_fetch_flag)
    else $error("advance together with fetch flag");
  a_other_lvls: assert property (
    $changed(o_level_req[13:0]) || $changed(o_level_req[15])
    |-> $past(i_reg_wr || i_give_up || i_ext_level_req != 16'h0000))
    else $error("other level request changed by event");
  a_giveup_clr: assert property (i_give_up && i_cur_level < 4'he &&
    !i_reg_wr && i_ext_level_req == 16'h0000
    |=> !o_level_req[$past(i_cur_level)])
    else $error("give up left running level request");
endmodule : status_irq_sva
bind internal_status_interrupt_unit status_irq_sva #(
  .FETCH_OP_BASE(FETCH_OP_BASE)
) i_sva (
  .i_clk, .i_sys_rst, .i_reg_wr, .i_reg_rd, .i_reg_sel, .i_cur_level,
  .i_give_up, .i_ext_level_req, .i_svc_call, .i_svc_num, .i_ref_type_bad,
  .i_ring_violation, .i_page_missing, .i_fetch_cycle, .o_rd_data,
  .o_rd_valid, .o_level_req, .o_pc_advance, .o_pc_hold,
  .o_pgs_fetch_flag, .o_t14_load, .o_t14_value
);
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import status_irq_pkg::*;
  typedef struct packed {logic [15:0] ev; logic [3:0] code;} row_t;
  localparam logic [15:0] OPB    = 16'h4400;
  localparam logic [15:0] PRIOR3 = 16'h4418;
  localparam logic [15:0] FA     = 16'hbe5a;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, top = 1'b0;
  logic        give_up = 1'b0, fetch = 1'b0, eclr = 1'b0;
  logic        rvalid, sw, adv, hold, paging_status_reg, t14l;
  logic [2:0]  sel = 3'h0, pc;
  logic [3:0]  cur, nl;
  logic [15:0] wdata = 16'h0000, ev = 16'h0000;
  logic [15:0] rdata, lreq, eflags, t14v, tv;
  int          err_count = 0;
  int          compares = 0;
  row_t        rows [15] = '{'{16'h0002, 4'h1}, '{16'h0004, 4'h2},
    '{16'h0008, 4'h3}, '{16'h0010, 4'h4}, '{16'h0020, 4'h5},
    '{16'h0040, 4'h6}, '{16'h0080, 4'h7}, '{16'h0100, CODE_PARITY},
    '{16'h0200, CODE_RANGE}, '{16'h0400, CODE_SUPPLY}, '{16'h0800, 4'h2},
    '{16'h1000, 4'h5}, '{16'h2000, 4'h5}, '{16'h4000, 4'h5},
    '{16'h8000, 4'h5}};
  row_t        frows [3] = '{'{16'h0008, 4'h3}, '{16'h0200, CODE_RANGE},
    '{16'h0010, 4'h4}};
  logic [2:0]  fexp [3] = '{3'b011, 3'b010, 3'b100};

  always #25 clk = ~clk;

  internal_status_interrupt_unit #(.FETCH_OP_BASE(OPB))
  i_internal_status_interrupt_unit (
    .i_clk(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_sel(sel), .i_wr_data(wdata), .o_rd_data(rdata),
    .o_rd_valid(rvalid), .i_cur_level(cur), .i_level_switch(sw),
    .i_new_level(nl), .i_give_up(give_up), .i_ext_level_req(16'h0000),
    .o_level_req(lreq), .i_svc_call(ev[1]), .i_svc_num(8'h85),
    .i_ref_type_bad(ev[2]), .i_ring_violation(ev[11]),
    .i_page_missing(ev[3]), .i_bad_opcode(ev[4]),
    .i_priv_op_fault(ev[6]), .i_io_no_connect(ev[7]),
    .i_mem_parity_fault(ev[8]), .i_addr_out_of_range(ev[9]),
    .i_fault_addr(FA), .i_fetch_cycle(fetch), .i_supply_loss(ev[10]),
    .i_fdiv_zero(ev[12]), .i_exec_of_exec(ev[13]),
    .i_denorm_ovf(ev[14]), .i_reg_divide_ovf(ev[15]),
    .i_err_flag_set(ev[5]), .i_err_flag_clr(eclr),
    .i_err_flag_level(4'h3), .o_err_flags(eflags), .o_pc_advance(adv),
    .o_pc_hold(hold), .o_pgs_fetch_flag(paging_status_reg), .o_t14_load(t14l),
    .o_t14_value(t14v));

  level_seq_model i_level_seq_model (
    .i_clk(clk), .i_sys_rst(rst), .i_level_req(lreq), .i_base(4'h3),
    .i_want_top(top), .o_cur_level(cur), .o_level_switch(sw),
    .o_new_level(nl));

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic rd_chk(input logic [2:0] s, input logic [15:0] exp);
    @(posedge clk);
    rd  <= 1'b1;
    sel <= s;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp({15'h0000, rvalid}, 16'h0001);
    cmp(rdata, exp);
  endtask : rd_chk

  task automatic fire(input logic [15:0] v);
    @(posedge clk);
    ev <= v;
    repeat (v[SRC_SUPPLY] ? 5 : 1) @(posedge clk);
    ev <= 16'h0000;
    @(negedge clk);
    pc = {adv, hold, paging_status_reg};
    tv = t14v;
  endtask : fire

  task automatic wait_lvl(input logic [3:0] l);
    int n;
    n = 0;
    while (cur !== l && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (cur !== l) begin
      err_count++;
      $display("wrong value at %0t: level %h not reached", $time, l);
      end_of_test();
    end
  endtask : wait_lvl

  task automatic pulse_give_up;
    @(posedge clk);
    give_up <= 1'b1;
    @(posedge clk);
    give_up <= 1'b0;
  endtask : pulse_give_up

  // level 14 software: clear the flag, give up, back to base
  task automatic leave;
    @(posedge clk);
    eclr <= 1'b1;
    @(posedge clk);
    eclr <= 1'b0;
    pulse_give_up();
    wait_lvl(4'h3);
    cmp(lreq, 16'h0000);
  endtask : leave

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    cmp(lreq, LEVEL_REQ_RST);
    cmp(eflags, ERR_FLAGS_RST);
    rd_chk(SEL_PRIOR_LEVEL, OPB);
    fire(16'h0008);
    rd_chk(SEL_EVENT_CODE, 16'h0000);
    cmp(lreq, 16'h0000);
    @(posedge clk);
    wr    <= 1'b1;
    sel   <= SEL_LEVEL_REQ;
    wdata <= 16'h0008;
    @(posedge clk);
    wr <= 1'b0;
    rd_chk(SEL_LEVEL_REQ, 16'h0008);
    pulse_give_up();
    @(negedge clk);
    cmp(lreq, 16'h0000);
    $display("test reset_and_mask done");
    @(posedge clk);
    wr    <= 1'b1;
    sel   <= SEL_EVENT_EN;
    wdata <= 16'h07fe;
    @(posedge clk);
    wr <= 1'b0;
    for (int i = 0; i < 15; i++) begin
      fire(rows[i].ev);
      if (rows[i].ev[SRC_SVC]) cmp(tv, 16'hff85);
      wait_lvl(LEVEL_INTERNAL);
      cmp(lreq, 16'h4000);
      rd_chk(SEL_EVENT_CODE, {12'h000, rows[i].code});
      if (rows[i].ev[9:8] != 2'b00) rd_chk(SEL_FAULT_ADDR, FA);
      leave();
      rd_chk(SEL_EVENT_CODE, 16'h0000);
    end
    $display("test source_rows done");
    fire(16'h0010);
    wait_lvl(LEVEL_INTERNAL);
    rd_chk(SEL_PRIOR_LEVEL, PRIOR3);
    rd_chk(SEL_EVENT_CODE, 16'h0004);
    leave();
    @(posedge clk);
    top <= 1'b1;
    wait_lvl(LEVEL_FAST);
    fire(16'h0010);
    @(posedge clk);
    top <= 1'b0;
    wait_lvl(LEVEL_INTERNAL);
    rd_chk(SEL_PRIOR_LEVEL, PRIOR3);
    rd_chk(SEL_EVENT_CODE, 16'h0004);
    leave();
    $display("test prior_level done");
    @(posedge clk);
    fetch <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      fire(frows[i].ev);
      cmp({13'h0000, pc}, {13'h0000, fexp[i]});
      wait_lvl(LEVEL_INTERNAL);
      rd_chk(SEL_EVENT_CODE, {12'h000, frows[i].code});
      leave();
    end
    @(posedge clk);
    fetch <= 1'b0;
    $display("test fetch_faults done");
    fire(16'h1000);
    wait_lvl(LEVEL_INTERNAL);
    cmp(eflags, 16'h0008);
    rd_chk(SEL_EVENT_CODE, 16'h0005);
    pulse_give_up();
    wait_lvl(4'h3);
    wait_lvl(LEVEL_INTERNAL);
    rd_chk(SEL_EVENT_CODE, 16'h0005);
    leave();
    rd_chk(SEL_EVENT_CODE, 16'h0000);
    cmp(eflags, 16'h0000);
    $display("test error_flag done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
